// ---- src/drc_pkg.sv ----
// constants and register map of the stereo dynamic range controller
package drc_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_FX_STATE = 12'hE01;
  localparam logic [11:0] IDX_CTRL1    = 12'hE80;
  localparam logic [11:0] IDX_CTRL2    = 12'hE81;
  localparam logic [11:0] IDX_CTRL3    = 12'hE82;
  localparam logic [11:0] IDX_CTRL4    = 12'hE83;
  localparam logic [11:0] IDX_CTRL5    = 12'hE84;
  localparam logic [11:0] IDX_STATUS   = 12'hE88;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_REN = 0;
  localparam int B_LEN = 1;
  localparam int B_SEQ = 2;
  localparam int B_CLIP = 3;
  localparam int B_QR = 4;
  localparam int B_K2OP = 5;
  localparam int B_SDEN = 6;
  localparam int B_SDMODE = 7;
  localparam int B_GATE = 8;
  localparam int F_PK = 9;
  localparam int F_RMS = 11;
  localparam int F_ATK = 9;
  localparam int F_DCY = 5;
  localparam int F_MIN = 2;
  localparam int F_MAX = 0;
  localparam int F_NGMIN = 12;
  localparam int F_NGEXP = 10;
  localparam int F_QRTHR = 8;
  localparam int F_QRDCY = 6;
  localparam int F_HI = 3;
  localparam int F_LO = 0;
  localparam int F_K1IP = 5;
  localparam int F_K1OP = 0;
  localparam int F_K2IP = 5;
  localparam int F_K2OP = 0;
  localparam int B_FX_L = 4;
  localparam int B_FX_R = 5;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CTRL1 = 16'h0018;
  localparam logic [15:0] RST_CTRL2 = 16'h0933;
  localparam logic [15:0] RST_CTRL3 = 16'h0018;
  localparam logic [15:0] RST_CTRL4 = 16'h0000;
  localparam logic [15:0] RST_CTRL5 = 16'h0000;
  // ----------------------------------------------------------------
  // timing: gain held in 0.75 dB units with GAIN_FRAC fraction bits
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int GAIN_FRAC = 12;
  localparam longint FS_HZ = 48000;
  localparam longint ATK1_NS = 181000;
  localparam longint DCY0_NS = 1450000;
  localparam longint QRDCY0_NS = 725000;
  localparam longint UNITS_6DB = 8;
  localparam int ATK1_STEP =
    int'(((UNITS_6DB <<< GAIN_FRAC) * 1000000000) / (ATK1_NS * FS_HZ));
  localparam int DCY0_STEP =
    int'(((UNITS_6DB <<< GAIN_FRAC) * 1000000000) / (DCY0_NS * FS_HZ));
  localparam int QRDCY0_STEP =
    int'(((UNITS_6DB <<< GAIN_FRAC) * 1000000000) / (QRDCY0_NS * FS_HZ));
  // ----------------------------------------------------------------
  // level curve constants in 0.75 dB attenuation units; MANT holds the gain mantissa per 0.75 dB step
  // ----------------------------------------------------------------
  localparam logic signed [12:0] LOG_FS = 13'h00B8;
  localparam logic signed [12:0] K2I_BASE = 13'h0030;
  localparam logic signed [12:0] K2O_BASE = 13'h0028;
  localparam logic signed [12:0] RMS_THR_BASE = 13'h0028;
  localparam logic signed [12:0] PK_THR_BASE = 13'h0010;
  localparam logic signed [12:0] NGMIN_BASE = 13'h0030;
  localparam logic [15:0] MANT [8] = '{16'h8000, 16'h7560, 16'h6BA2,
    16'h62B4, 16'h5A82, 16'h52FF, 16'h4C1C, 16'h45CB};
endpackage

// ---- src/drc_top.sv ----
// stereo dynamic range controller: channel datapath and register slave
// Contract
// - gate bit clear: ignore knee2 and expansion, lower slope below knee1
// - knee2 output enable clear: knee2 sits on the lower-slope curve
// - knee1 is placed by the knee1 input and output level fields
// - full-scale output equals knee1 output minus knee1 input times upper slope
// - gain clamped by compression minimum, gate minimum and boost maximum
// - level estimate is a time-averaged RMS, not single samples
// - gain falls at attack rate when loud, rises at decay rate when quiet
// - clip guard, default on, looks ahead and speeds up the attack
// - the look-ahead adds latency to the sample path
// - fast recover, default on, measures crest factor peak over RMS
// - crest above fast-recover threshold selects the fast decay rate
// - activity detection runs only with its enable and the channel enabled
// - activity select 0 compares crest factor, 1 compares RMS level
// - peak threshold codes give 12, 18, 24, 30 dB; reset 00
// - RMS threshold -30 dB at 00h, 1.5 dB lower per step
// - activity output goes to the interrupt and general-purpose pin
// - sequencer trigger fires on activity only when enabled
// - clip flag set on clip-guard attack, held until gain is steady
// - decay flag set while gain rises, cleared on the first sample it does not rise
// - gate flag shows the noise gate has triggered
// - fast-recover flag set on fast decay, held until gain is steady
// - effects state shows right enable at bit 5, left at bit 4
// - control word bit 1 enables left, bit 0 right; reset off
// - sequencer trigger enable is control word bit 2, reset off
// - enable refused when core clock is too slow; active paths kept
//
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module drc_chan
  import drc_pkg::*;
#(
  parameter int LOOKAHEAD = 4,
  parameter int AVG_SH    = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        en_i,
  input  wire logic        smp_i,
  input  wire logic [23:0] din_i,
  input  wire logic [15:0] c1_i,
  input  wire logic [15:0] c2_i,
  input  wire logic [15:0] c3_i,
  input  wire logic [15:0] c4_i,
  input  wire logic [15:0] c5_i,
  output logic      [23:0] dout_o,
  output logic             clip_o,
  output logic             dcy_o,
  output logic             gate_o,
  output logic             qr_o,
  output logic             act_o
);
  typedef logic signed [12:0] drc_s13_t;

  function automatic logic [7:0] log4(input logic [45:0] v);
    logic [7:0]  r;
    logic [47:0] t;
    r = 8'h00;
    t = {v, 2'b00};
    for (int i = 2; i < 48; i++) begin
      if (t[i]) begin
        r = {6'(i - 2), t[i-1], t[i-2]};
      end
    end
    return r;
  endfunction

  function automatic drc_s13_t cslope(input drc_s13_t v,
                                      input logic [2:0] c, input logic hi);
    case (c)
      3'h0: return v;
      3'h1: return v >>> 1;
      3'h2: return v >>> 2;
      3'h3: return v >>> 3;
      3'h4: return hi ? (v >>> 4) : 13'h0000;
      default: return 13'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // level estimate
  // ----------------------------------------------------------------
  logic [45:0] pwr_q;
  logic [45:0] pwr_d;
  logic [22:0] mag;
  logic [45:0] sq;
  drc_s13_t    lvl;
  drc_s13_t    pk;
  drc_s13_t    crest;

  assign mag = din_i[23] ? ((din_i == 24'h800000) ? 23'h7FFFFF
                            : 23'(-din_i)) : din_i[22:0];
  assign sq  = mag * mag;
  assign pwr_d = pwr_q - (pwr_q >> AVG_SH) + (sq >> AVG_SH);
  assign lvl   = LOG_FS - drc_s13_t'({5'h00, log4(pwr_q)});
  assign pk    = LOG_FS - drc_s13_t'({4'h0, log4({23'h0, mag}), 1'b0});
  // crest factor in 0.75 dB units
  assign crest = lvl - pk;

  // ----------------------------------------------------------------
  // static curve
  // ----------------------------------------------------------------
  drc_s13_t k1i, k1o, y0, k2i, k2o, out_a, tgt, lim_lo, lim_hi, gmin;
  logic     in_gate;

  assign k1i = drc_s13_t'({7'h00, c4_i[F_K1IP+:6]});
  assign k1o = drc_s13_t'({8'h00, c4_i[F_K1OP+:5]});
  assign y0  = k1o - cslope(k1i, c3_i[F_HI+:3], 1'b1);
  assign k2i = K2I_BASE + drc_s13_t'({7'h00, c5_i[F_K2IP+:5], 1'b0});
  // knee2 output fixed or on the lower slope
  assign k2o = c1_i[B_K2OP]
             ? K2O_BASE + drc_s13_t'({7'h00, c5_i[F_K2OP+:5], 1'b0})
             : k1o + cslope(k2i - k1i, c3_i[F_LO+:3], 1'b0);
  // gate region only with the gate bit set
  assign in_gate = c1_i[B_GATE] && (lvl > k2i);

  always_comb begin
    if (lvl <= k1i) begin
      out_a = y0 + cslope(lvl, c3_i[F_HI+:3], 1'b1);
    end else if (!in_gate) begin
      out_a = k1o + cslope(lvl - k1i, c3_i[F_LO+:3], 1'b0);
    end else begin
      out_a = k2o + ((lvl - k2i) <<< c3_i[F_NGEXP+:2]);
    end
  end

  always_comb begin
    case (c2_i[F_MIN+:3])
      3'h0: gmin = 13'h0000;
      3'h1: gmin = 13'h0010;
      3'h2: gmin = 13'h0018;
      3'h3: gmin = 13'h0020;
      default: gmin = 13'h0030;
    endcase
  end

  assign lim_lo = in_gate
                ? NGMIN_BASE - drc_s13_t'({6'h00, c3_i[F_NGMIN+:4], 3'h0})
                : gmin;
  // boost limit 12, 18, 24 dB in 6 dB steps; code 3 jumps to 36 dB
  assign lim_hi = -drc_s13_t'({7'h00, 3'(c2_i[F_MAX+:2]) + 3'h2, 3'h0})
                  - ((c2_i[F_MAX+:2] == 2'h3) ? 13'h0008 : 13'h0000);

  // clamp attenuation between limits, boost limit last
  always_comb begin
    tgt = out_a - lvl;
    if (tgt > lim_lo) begin
      tgt = lim_lo;
    end
    if (tgt < lim_hi) begin
      tgt = lim_hi;
    end
  end

  // ----------------------------------------------------------------
  // gain dynamics
  // ----------------------------------------------------------------
  logic signed [19:0] g_q, g_d, t_fx, atk, atk_n, dcy;
  logic [3:0]         atk_c;
  logic               clip_hit, qr_hit, loud, quiet;

  assign t_fx  = 20'(tgt) <<< GAIN_FRAC;
  assign atk_c = (c2_i[F_ATK+:4] == 4'h0) ? 4'h1
               : (c2_i[F_ATK+:4] > 4'hB) ? 4'hB : c2_i[F_ATK+:4];
  // new sample would exceed full scale at present gain
  assign clip_hit = c1_i[B_CLIP] && (pk + drc_s13_t'(g_q >>> GAIN_FRAC) < 0);
  // fast decay when crest passes its threshold
  assign qr_hit = c1_i[B_QR] &&
                  (crest > PK_THR_BASE
                   + drc_s13_t'({8'h00, c3_i[F_QRTHR+:2], 3'h0}));
  assign atk_n = 20'(ATK1_STEP) >> (atk_c - 4'h1);
  // clip guard makes the attack step eight times larger
  assign atk   = clip_hit ? (atk_n <<< 3) : atk_n;
  always_comb begin
    if (qr_hit) begin
      case (c3_i[F_QRDCY+:2])
        2'h0: dcy = 20'(QRDCY0_STEP);
        2'h1: dcy = 20'(DCY0_STEP);
        default: dcy = 20'(DCY0_STEP) >> 2;
      endcase
    end else begin
      dcy = 20'(DCY0_STEP) >> ((c2_i[F_DCY+:4] > 4'hB) ? 4'hB
                               : c2_i[F_DCY+:4]);
    end
    // limitation: the slowest codes round up to one step per sample
    if (dcy == 20'sd0) begin
      dcy = 20'sd1;
    end
  end
  assign loud  = t_fx > g_q;
  assign quiet = t_fx < g_q;

  // step toward target at attack or decay rate
  always_comb begin
    g_d = g_q;
    if (loud) begin
      g_d = (t_fx - g_q > atk) ? g_q + atk : t_fx;
    end else if (quiet) begin
      g_d = (g_q - t_fx > dcy) ? g_q - dcy : t_fx;
    end
  end

  // ----------------------------------------------------------------
  // look-ahead delay and gain application
  // ----------------------------------------------------------------
  logic signed [23:0] dl_q [LOOKAHEAD];
  logic signed [7:0]  gi;
  logic signed [40:0] prod;
  logic signed [47:0] scl, shd;
  logic [23:0]        y;

  assign gi   = 8'(g_q >>> GAIN_FRAC);
  assign prod = dl_q[LOOKAHEAD-1] * $signed({1'b0, MANT[gi[2:0]]});
  assign scl  = 48'(prod >>> 15);
  assign shd  = gi[7] ? (scl <<< (3'h0 - 3'(gi >>> 3)))
                      : (scl >>> 3'(gi >>> 3));
  assign y = (shd > 48'sh7FFFFF) ? 24'h7FFFFF
           : (shd < -48'sh800000) ? 24'h800000 : shd[23:0];

  // one update per sample while enabled
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      pwr_q  <= '0;
      g_q    <= '0;
      dout_o <= 24'h000000;
      clip_o <= 1'b0;
      dcy_o  <= 1'b0;
      gate_o <= 1'b0;
      qr_o   <= 1'b0;
      act_o  <= 1'b0;
    end else if (smp_i) begin
      pwr_q  <= pwr_d;
      g_q    <= g_d;
      dout_o <= y;
      // clip flag held until the gain settles
      clip_o <= (loud && clip_hit) || (clip_o && (loud || quiet));
      dcy_o  <= quiet;
      gate_o <= in_gate;
      // fast-recover flag held until the gain settles
      qr_o   <= (quiet && qr_hit) || (qr_o && (loud || quiet));
      act_o  <= c1_i[B_SDEN] && (c1_i[B_SDMODE]
        // 30 dB plus 1.5 dB per code
        ? (lvl < RMS_THR_BASE + drc_s13_t'({7'h00, c1_i[F_RMS+:5], 1'b0}))
        // 12 dB plus 6 dB per code
        : (crest > PK_THR_BASE + drc_s13_t'({8'h00, c1_i[F_PK+:2], 3'h0})));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < LOOKAHEAD; i++) begin
        dl_q[i] <= 24'h000000;
      end
    end else if (smp_i) begin
      dl_q[0] <= din_i;
      for (int i = 1; i < LOOKAHEAD; i++) begin
        dl_q[i] <= dl_q[i-1];
      end
    end
  end

  a_gate_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !c1_i[B_GATE] && en_i && smp_i |=> !gate_o)
    else $error("gate flag with gate disabled");
  a_decay_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && smp_i && quiet ##1 en_i |-> dcy_o)
    else $error("decay flag missing while gain rises");
  a_gain_ceiling: assert property (@(posedge clk_i) disable iff (rst_i)
    (g_q >>> GAIN_FRAC) >= -20'sd48 && (g_q >>> GAIN_FRAC) <= 20'sd48)
    else $error("gain left its clamp range");
  a_qr_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(qr_o) |-> $past(c1_i[B_QR]))
    else $error("fast-recover flag without enable");
endmodule

module drc_top
  import drc_pkg::*;
#(
  parameter int LOOKAHEAD = 4,
  parameter int AVG_SH    = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        clk_ok_i,
  input  wire logic        smp_valid_i,
  input  wire logic [23:0] left_i,
  input  wire logic [23:0] right_i,
  output logic      [23:0] left_o,
  output logic      [23:0] right_o,
  output logic             out_valid_o,
  output logic             act_gpio_o,
  output logic             act_irq_o,
  output logic             seq_trig_o
);
  if (LOOKAHEAD < 1 || AVG_SH < 1 || AVG_SH > 20) begin : g_chk
    $error("drc_top: LOOKAHEAD must be >= 1 and AVG_SH in 1..20");
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [15:0] c1_q, c2_q, c3_q, c4_q, c5_q, wv, c1_new;
  logic [1:0]  en_q, en_d;
  logic        req, wr, act_q;
  logic [11:0] idx;
  logic [31:0] rd;
  wire  [5:0]  fl_l, fl_r;
  wire         act_any;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i;
  assign idx = wb_adr_i[13:2];
  assign wv  = wb_dat_i[15:0];

  function automatic logic [15:0] merge(input logic [15:0] o,
                                        input logic [15:0] n,
                                        input logic [1:0]  s);
    return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
  endfunction

  // new enables need enough core clock; running paths stay
  assign c1_new = merge(c1_q, wv, wb_sel_i[1:0]);
  assign en_d   = (wr && idx == IDX_CTRL1)
                ? (c1_new[1:0] & (en_q | {2{clk_ok_i}}))
                : en_q;

  always_comb begin
    case (idx)
      // right at bit 5, left at bit 4
      IDX_FX_STATE: rd = 32'(en_q[B_REN]) << B_FX_R
                       | 32'(en_q[B_LEN]) << B_FX_L;
      IDX_CTRL1:    rd = {16'h0000, c1_q};
      IDX_CTRL2:    rd = {16'h0000, c2_q};
      IDX_CTRL3:    rd = {16'h0000, c3_q};
      IDX_CTRL4:    rd = {16'h0000, c4_q};
      IDX_CTRL5:    rd = {16'h0000, c5_q};
      IDX_STATUS:   rd = {19'h00000, act_q, fl_l, fl_r};
      default:      rd = 32'h00000000;
    endcase
  end

  // control word reset, left bit 1 right bit 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c1_q <= RST_CTRL1;
      c2_q <= RST_CTRL2;
      c3_q <= RST_CTRL3;
      c4_q <= RST_CTRL4;
      c5_q <= RST_CTRL5;
      en_q <= 2'h0;
    end else begin
      en_q <= en_d;
      if (wr && idx == IDX_CTRL1) c1_q <= merge(c1_q, wv, wb_sel_i[1:0]);
      if (wr && idx == IDX_CTRL2) c2_q <= merge(c2_q, wv, wb_sel_i[1:0]);
      if (wr && idx == IDX_CTRL3) c3_q <= merge(c3_q, wv, wb_sel_i[1:0]);
      if (wr && idx == IDX_CTRL4) c4_q <= merge(c4_q, wv, wb_sel_i[1:0]);
      if (wr && idx == IDX_CTRL5) c5_q <= merge(c5_q, wv, wb_sel_i[1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // channels and activity outputs
  // ----------------------------------------------------------------
  wire act_l, act_r;

  drc_chan #(.LOOKAHEAD(LOOKAHEAD), .AVG_SH(AVG_SH)) u_left (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(en_q[B_LEN]), .smp_i(smp_valid_i),
    .din_i(left_i), .c1_i(c1_q), .c2_i(c2_q), .c3_i(c3_q), .c4_i(c4_q),
    .c5_i(c5_q), .dout_o(left_o), .clip_o(fl_l[0]), .dcy_o(fl_l[1]),
    .gate_o(fl_l[2]), .qr_o(fl_l[3]), .act_o(act_l));
  drc_chan #(.LOOKAHEAD(LOOKAHEAD), .AVG_SH(AVG_SH)) u_right (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(en_q[B_REN]), .smp_i(smp_valid_i),
    .din_i(right_i), .c1_i(c1_q), .c2_i(c2_q), .c3_i(c3_q), .c4_i(c4_q),
    .c5_i(c5_q), .dout_o(right_o), .clip_o(fl_r[0]), .dcy_o(fl_r[1]),
    .gate_o(fl_r[2]), .qr_o(fl_r[3]), .act_o(act_r));

  assign fl_l[5:4] = {act_l, en_q[B_LEN]};
  assign fl_r[5:4] = {act_r, en_q[B_REN]};
  // each channel reports only while enabled
  assign act_any = (act_l && en_q[B_LEN]) || (act_r && en_q[B_REN]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_q       <= 1'b0;
      act_gpio_o  <= 1'b0;
      act_irq_o   <= 1'b0;
      seq_trig_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      act_q       <= act_any;
      // level to the pin, rising edge to the interrupt
      act_gpio_o  <= act_any;
      act_irq_o   <= act_any && !act_q;
      // sequencer trigger gated by its enable
      seq_trig_o  <= act_any && !act_q && c1_q[B_SEQ];
      out_valid_o <= smp_valid_i && (en_q != 2'h0);
    end
  end

  a_refuse_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_CTRL1 && !clk_ok_i && !en_q[0] |=> !en_q[0])
    else $error("enable taken while core clock too slow");
  a_keep_active: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr && en_q[1] |=> en_q[1])
    else $error("active left path dropped without a write");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_seq_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_trig_o |-> $past(c1_q[B_SEQ]))
    else $error("sequencer trigger while disabled");
  a_act_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    en_q == 2'h0 ##1 en_q == 2'h0 |-> !act_gpio_o)
    else $error("activity with both channels off");
  a_fx_state: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == IDX_FX_STATE |=>
      wb_dat_o[5:4] == {$past(en_q[0]), $past(en_q[1])})
    else $error("effects state does not match enables");
endmodule

`default_nettype wire

// ---- tb/drc_src_model.sv ----
// sample source standing in for the routing mixers
`timescale 1ns/10ps
`default_nettype none
module drc_src_model #(
  parameter int GAP = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic [23:0] amp_i,
  output logic             smp_valid_o,
  output logic      [23:0] left_o,
  output logic      [23:0] right_o
);
  int   cnt;
  logic neg_q;
  // between strobes the sample lines toggle, so the last sample alternates with its complement
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt         <= 0;
      neg_q       <= 1'b0;
      smp_valid_o <= 1'b0;
      left_o      <= 24'h000000;
      right_o     <= 24'h000000;
    end else if (run_i && cnt == GAP - 1) begin
      cnt         <= 0;
      neg_q       <= ~neg_q;
      smp_valid_o <= 1'b1;
      left_o      <= neg_q ? ~amp_i + 24'h000001 : amp_i;
      right_o     <= neg_q ? ~amp_i + 24'h000001 : amp_i;
    end else begin
      cnt         <= run_i ? cnt + 1 : 0;
      smp_valid_o <= 1'b0;
      left_o      <= ~left_o;
      right_o     <= ~right_o;
    end
  end
endmodule
`default_nettype wire

// ---- tb/drc_top_tb.sv ----
// self-checking bench for the dynamics controller
`timescale 1ns/10ps
`default_nettype none
module drc_top_tb;
  import drc_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, clk_ok, run, ack;
  logic        ov, gpio, irq, trig, smp;
  logic [15:0] adr;
  logic [31:0] wdat, rdat, dat_o;
  logic [23:0] amp, l_in, r_in, l_out, r_out;
  int          n_fail, n_compared, n_irq, n_trig;

  drc_src_model src_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
    .amp_i(amp), .smp_valid_o(smp), .left_o(l_in), .right_o(r_in));
  drc_top #(.LOOKAHEAD(4), .AVG_SH(2)) dut_u (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .clk_ok_i(clk_ok), .smp_valid_i(smp), .left_i(l_in),
    .right_i(r_in), .left_o(l_out), .right_o(r_out), .out_valid_o(ov),
    .act_gpio_o(gpio), .act_irq_o(irq), .seq_trig_o(trig));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (irq === 1'b1) n_irq++;
    if (trig === 1'b1) n_trig++;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] idx,
                    input logic [15:0] d);
    int k;
    k = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {2'b00, idx, 2'b00};
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    check({31'h0, ack}, 32'h1);
    if (ack !== 1'b1) results();
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000);
    check(rdat, {16'h0000, exp});
  endtask
  task automatic wait_ov();
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ov !== 1'b1 && k < 40);
    check({31'h0, ov}, 32'h1);
    if (ov !== 1'b1) results();
  endtask
  task automatic wait_gpio(input logic v);
    int k;
    k = 0;
    while (gpio !== v && k < 20000) begin
      @(posedge clk_i);
      k++;
    end
    check({31'h0, gpio}, {31'h0, v});
    if (gpio !== v) results();
    @(posedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(IDX_CTRL1, 16'h0018);
    rd(IDX_CTRL2, 16'h0933);
    rd(IDX_CTRL3, 16'h0018);
    rd(IDX_CTRL4, 16'h0000);
    rd(IDX_CTRL5, 16'h0000);
    rd(IDX_FX_STATE, 16'h0000);
    rd(12'h123, 16'h0000);
  endtask
  task automatic t_latency();
    wb(1'b1, IDX_CTRL1, 16'h001A);
    rd(IDX_FX_STATE, 16'h0010);
    amp <= 24'h400000;
    run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wait_ov();
      check({8'h00, l_out}, 32'h0);
      check({8'h00, r_out}, 32'h0);
    end
    wait_ov();
    check({8'h00, l_out}, 32'h00400000);
  endtask
  task automatic t_refuse();
    clk_ok <= 1'b0;
    wb(1'b1, IDX_CTRL1, 16'h001B);
    rd(IDX_FX_STATE, 16'h0010);
    clk_ok <= 1'b1;
    wb(1'b1, IDX_CTRL1, 16'h0018);
    wb(1'b1, IDX_CTRL1, 16'h001B);
    clk_ok <= 1'b0;
    rd(IDX_FX_STATE, 16'h0030);
    clk_ok <= 1'b1;
  endtask
  task automatic t_activity();
    int seen;
    seen = 0;
    wb(1'b1, IDX_CTRL1, 16'h00D8);
    repeat (2000) begin
      @(posedge clk_i);
      if (gpio !== 1'b0) seen++;
    end
    check(seen, 0);
    n_irq = 0;
    n_trig = 0;
    wb(1'b1, IDX_CTRL1, 16'h00DB);
    wait_gpio(1'b1);
    check(n_irq, 1);
    check(n_trig, 0);
    amp <= 24'h000010;
    wait_gpio(1'b0);
    wb(1'b1, IDX_CTRL1, 16'h00DF);
    amp <= 24'h400000;
    wait_gpio(1'b1);
    check(n_trig, 1);
    check(n_irq, 2);
  endtask
  task automatic t_peak();
    amp <= 24'h000010;
    wb(1'b1, IDX_CTRL1, 16'h065B);
    repeat (200) @(posedge clk_i);
    wait_gpio(1'b0);
    wb(1'b0, IDX_STATUS, 16'h0000);
    check({30'h0, rdat[8], rdat[2]}, 32'h0);
    wb(1'b1, IDX_CTRL1, 16'h075B);
    repeat (40) @(posedge clk_i);
    wb(1'b0, IDX_STATUS, 16'h0000);
    check({30'h0, rdat[8], rdat[2]}, 32'h3);
    amp <= 24'h400000;
    wait_gpio(1'b1);
    check(n_irq, 3);
    check(n_trig, 1);
  endtask

  initial begin
    rst_i      = 1'b1;
    cyc        = 1'b0;
    stb        = 1'b0;
    we         = 1'b0;
    adr        = 16'h0000;
    wdat       = 32'h0;
    clk_ok     = 1'b1;
    run        = 1'b0;
    amp        = 24'h000000;
    n_fail     = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_latency();
    t_refuse();
    t_activity();
    t_peak();
    results();
  end
endmodule
`default_nettype wire
